// ---- src/qmec_pkg.sv ----
package qmec_pkg;
  // instruction codes
  localparam logic [7:0] QMEC_CMD_RDSR1   = 8'h05;
  localparam logic [7:0] QMEC_CMD_RDSR2   = 8'h35;
  localparam logic [7:0] QMEC_CMD_WRSR    = 8'h01;
  localparam logic [7:0] QMEC_CMD_CFG_RD  = 8'h65;
  localparam logic [7:0] QMEC_CMD_CFG_WR  = 8'h71;
  localparam logic [7:0] QMEC_CMD_QIOR    = 8'heb;
  // mode bit patterns
  localparam logic [7:0] QMEC_MODE_ENTER  = 8'ha5;
  localparam logic [7:0] QMEC_MODE_EXIT   = 8'h00;
  localparam logic [3:0] QMEC_MODE_HI     = 4'ha;
  localparam logic [3:0] QMEC_RESET_NIB   = 4'hf;
  localparam int         QMEC_RESET_CLKS  = 8;
  // field positions
  localparam int         QMEC_QUAD_EN_BIT = 1;
  localparam int         QMEC_BUSY_BIT    = 0;
  localparam int         QMEC_QPI_BIT     = 6;
  localparam logic [23:0] QMEC_CFG_ADDR   = 24'h800003;
  localparam int         QMEC_ADDR_NIBS   = 6;
  // busy time after status/config write, in ns
  localparam int         QMEC_WRITE_NS    = 1000;
  localparam int         QMEC_CLK_MHZ     = 200;
  localparam int         QMEC_WRITE_CYC   = (QMEC_WRITE_NS * QMEC_CLK_MHZ + 999) / 1000;
  // apb register map
  localparam logic [11:0] QMEC_OFF_SR1    = 12'h000;
  localparam logic [11:0] QMEC_OFF_SR2    = 12'h004;
  localparam logic [11:0] QMEC_OFF_CFG    = 12'h008;
  localparam logic [11:0] QMEC_OFF_STAT   = 12'h00c;
  localparam logic [7:0]  QMEC_SR2_RST    = 8'h00;
  localparam logic [7:0]  QMEC_CFG_RST    = 8'h00;

  typedef struct packed {
    logic       valid;
    logic [7:0] sr2;
    logic [7:0] cfg;
  } qmec_wr_t;

  typedef struct packed {
    logic continuous;
    logic quad_cmd;
  } qmec_mode_t;
endpackage

// ---- src/qmec_sync.sv ----
`timescale 1ns/1ps
module qmec_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  initial begin
    if (W < 1) $error("qmec_sync width");
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      q      <= s1_reg;
    end
  end
endmodule // qmec_sync

// ---- src/qmec_top.sv ----
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// - the quad enable flag sits at bit one of status register two, apart from status one.
// - instruction 05h shifts out status register one.
// - instruction 35h shifts out status register two with the quad enable flag.
// - write status 01h takes two bytes and bit one of the second sets or clears quad enable.
// - mode bits a5h enter continuous 0-4-4 read, allowed only with quad enable set.
// - mode bits 00h leave continuous mode as soon as the mode byte completes; the current read still runs to its end.
// - fh on all four data lines for 8 clocks leaves continuous mode before the next read.
// - any mode byte whose high nibble is not ah also leaves continuous mode.
// - status one bit zero reads one while a status or config write is busy.
module qmec_top
  import qmec_pkg::*;
#(
  parameter int WRITE_CYC = QMEC_WRITE_CYC
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  quad_data_lines_in,
  output logic      [3:0]  quad_data_lines_out,
  output logic      [3:0]  quad_data_lines_oe
);
  import qmec_pkg::*;

  initial begin
    if (WRITE_CYC < 1) $error("qmec_top write time");
  end

  // ----------------------------------------
  // link domain: command decode on sck
  // ----------------------------------------
  typedef enum logic [3:0] {
    QMEC_S_CMD, QMEC_S_OUT, QMEC_S_WR1, QMEC_S_WR2, QMEC_S_ADDR,
    QMEC_S_MODE, QMEC_S_DUMMY, QMEC_S_DATA, QMEC_S_CFGDATA, QMEC_S_IDLE
  } qmec_state_t;

  qmec_state_t state_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  cnt_reg;
  logic [23:0] addr_reg;
  logic [7:0]  out_reg;
  logic [7:0]  wsr2_reg;
  logic [7:0]  wcfg_reg;
  logic        wtog_reg;
  logic        cont_reg;
  logic        cont_exit_reg;
  logic        cfg_rd_reg;
  logic [3:0]  fcnt_reg;
  logic        first_reg;
  logic        quad_out_reg;

  // status mirrors carried into sck domain
  logic [7:0] sr1_s;
  logic [7:0] sr2_s;
  logic [7:0] cfg_s;
  logic [7:0] sr1_p;
  logic [7:0] sr2_p;
  logic [7:0] cfg_p;

  wire       qpi_s     = cfg_s[QMEC_QPI_BIT];
  wire       quad_en_s = sr2_s[QMEC_QUAD_EN_BIT];
  wire       quad_in   = qpi_s;
  wire [7:0] byte1     = {shift_reg[6:0], quad_data_lines_in[0]};
  wire [7:0] nib_byte  = {shift_reg[3:0], quad_data_lines_in};
  wire       nib_half  = cnt_reg[0];
  wire       byte_done = quad_in ? nib_half : (cnt_reg == 4'd7);
  wire [7:0] rx_byte   = quad_in ? nib_byte : byte1;
  wire       all_f     = quad_data_lines_in == QMEC_RESET_NIB;
  // mode byte completes on second nibble
  wire [7:0] mode_byte = nib_byte;
  wire       mode_keep = (mode_byte[7:4] == QMEC_MODE_HI) && (mode_byte != QMEC_MODE_EXIT);
  // entry needs a5h and quad enable
  wire       mode_enter = (mode_byte == QMEC_MODE_ENTER) && quad_en_s;
  wire       mode_done  = state_reg == QMEC_S_MODE && nib_half;

  // cs_n async resets the link logic: the frame ends it, not a later sck edge
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      state_reg <= QMEC_S_CMD;
      cnt_reg   <= '0;
      first_reg <= 1'b1;
      fcnt_reg  <= '0;
    end else begin
      first_reg <= 1'b0;
      // address nibbles counted apart from bytes, in either input width
      cnt_reg   <= (state_reg == QMEC_S_ADDR) ? ((cnt_reg == 4'd5) ? 4'd0 : cnt_reg + 4'd1)
                   : ((byte_done || mode_done) ? 4'd0 : cnt_reg + 4'd1);
      fcnt_reg  <= all_f ? (fcnt_reg == 4'(QMEC_RESET_CLKS) ? fcnt_reg : fcnt_reg + 4'd1)
                         : 4'd0;
      case (state_reg)
        QMEC_S_CMD: begin
          if (first_reg && cont_reg) begin
            state_reg <= QMEC_S_ADDR;
            cnt_reg   <= 4'd1;
          end else if (byte_done) begin
            case (rx_byte)
              QMEC_CMD_RDSR1:  state_reg <= QMEC_S_OUT;
              QMEC_CMD_RDSR2:  state_reg <= QMEC_S_OUT;
              QMEC_CMD_WRSR:   state_reg <= QMEC_S_WR1;
              QMEC_CMD_CFG_RD: state_reg <= QMEC_S_ADDR;
              QMEC_CMD_CFG_WR: state_reg <= QMEC_S_ADDR;
              QMEC_CMD_QIOR:   state_reg <= QMEC_S_ADDR;
              default:         state_reg <= QMEC_S_IDLE;
            endcase
          end
        end
        QMEC_S_WR1:     if (byte_done) state_reg <= QMEC_S_WR2;
        QMEC_S_WR2:     if (byte_done) state_reg <= QMEC_S_IDLE;
        QMEC_S_ADDR: begin
          if (cnt_reg == 4'd5) begin
            if (shift_reg == QMEC_CMD_CFG_RD || shift_reg == QMEC_CMD_CFG_WR)
              state_reg <= shift_reg == QMEC_CMD_CFG_RD ? QMEC_S_OUT : QMEC_S_CFGDATA;
            else
              state_reg <= QMEC_S_MODE;
          end
        end
        QMEC_S_MODE:    if (nib_half) state_reg <= QMEC_S_DUMMY;
        QMEC_S_DUMMY:   if (cnt_reg == 4'd3) state_reg <= QMEC_S_DATA;
        QMEC_S_CFGDATA: if (byte_done) state_reg <= QMEC_S_IDLE;
        QMEC_S_OUT, QMEC_S_DATA, QMEC_S_IDLE: state_reg <= state_reg;
        default:        state_reg <= QMEC_S_IDLE;
      endcase
    end
  end

  // datapath on sck, reset only by presetn-free constants via cs_n
  logic [7:0] cmd_reg;
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      shift_reg <= '0;
      cmd_reg   <= '0;
      addr_reg  <= '0;
    end else begin
      shift_reg <= (state_reg == QMEC_S_ADDR) ? cmd_reg
                   : ((quad_in || state_reg == QMEC_S_MODE) ? nib_byte : byte1);
      if (state_reg == QMEC_S_CMD && byte_done) cmd_reg <= rx_byte;
      if (state_reg == QMEC_S_CMD && first_reg && cont_reg) cmd_reg <= QMEC_CMD_QIOR;
      if (state_reg == QMEC_S_ADDR) addr_reg <= {addr_reg[19:0], quad_data_lines_in};
    end
  end

  // continuous mode and write capture; these persist across frames
  always_ff @(posedge sck or negedge presetn) begin
    if (!presetn) begin
      cont_reg      <= 1'b0;
      cont_exit_reg <= 1'b0;
      wsr2_reg      <= QMEC_SR2_RST;
      wcfg_reg      <= QMEC_CFG_RST;
      wtog_reg      <= 1'b0;
    end else if (!cs_n) begin
      // exit takes effect on the sck edge that completes the mode byte
      if (mode_done) begin
        cont_reg <= mode_enter || (cont_reg && mode_keep);
      end
      // mode bit reset clears before next read
      if (fcnt_reg == 4'(QMEC_RESET_CLKS - 1) && all_f && state_reg != QMEC_S_DATA)
        cont_reg <= 1'b0;
      // second byte bit one drives quad enable
      if (state_reg == QMEC_S_WR2 && byte_done) begin
        wsr2_reg <= rx_byte;
        wcfg_reg <= cfg_s;
        wtog_reg <= ~wtog_reg;
      end
      if (state_reg == QMEC_S_CFGDATA && byte_done && addr_reg == QMEC_CFG_ADDR) begin
        wsr2_reg <= sr2_s;
        wcfg_reg <= rx_byte;
        wtog_reg <= ~wtog_reg;
      end
    end
  end

  // output: serial on line 1 or quad nibbles when 4-4-4 is on
  wire [7:0] out_src = (cmd_reg == QMEC_CMD_RDSR1) ? sr1_s :
                       (cmd_reg == QMEC_CMD_RDSR2) ? sr2_s : cfg_s;
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      out_reg      <= '0;
      quad_out_reg <= 1'b0;
      cfg_rd_reg   <= 1'b0;
    end else if (state_reg == QMEC_S_OUT) begin
      cfg_rd_reg   <= 1'b1;
      quad_out_reg <= quad_in;
      out_reg      <= !cfg_rd_reg ? out_src
                      : (quad_in ? {out_reg[3:0], out_reg[7:4]} : {out_reg[6:0], out_reg[7]});
    end
  end
  assign quad_data_lines_out = quad_out_reg ? out_reg[7:4] : {2'b00, out_reg[7], 1'b0};
  assign quad_data_lines_oe  = cfg_rd_reg ? (quad_out_reg ? 4'hf : 4'h2) : 4'h0;

  // ----------------------------------------
  // crossings
  // ----------------------------------------
  logic [7:0] sr2_reg;
  logic [7:0] cfg_reg;
  logic       busy_reg;
  logic [15:0] wait_reg;
  logic        tog_seen_reg;
  logic        wtog_p;
  logic        cont_p;

  // write words are stable once the toggle flips, so a toggle guards them
  qmec_sync #(.W(1)) u_sync_tog (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (wtog_reg),
    .q     (wtog_p)
  );
  qmec_sync #(.W(1)) u_sync_cont (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (cont_reg),
    .q     (cont_p)
  );
  // sck stops between frames, so these words settle on pclk;
  // they change only when a write is taken in or when its busy time runs out
  qmec_sync #(.W(24)) u_sync_stat (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({sr1_p, sr2_p, cfg_p}),
    .q     ({sr1_s, sr2_s, cfg_s})
  );

  // ----------------------------------------
  // pclk domain: status and busy
  // ----------------------------------------
  wire wr_evt = wtog_p != tog_seen_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr2_reg      <= QMEC_SR2_RST;
      cfg_reg      <= QMEC_CFG_RST;
      busy_reg     <= 1'b0;
      wait_reg     <= '0;
      tog_seen_reg <= 1'b0;
    end else begin
      tog_seen_reg <= wtog_p;
      if (wr_evt) begin
        sr2_reg  <= wsr2_reg;
        cfg_reg  <= wcfg_reg;
        busy_reg <= 1'b1;
        wait_reg <= 16'(WRITE_CYC);
      end else if (busy_reg) begin
        // busy clears when the write time elapses
        wait_reg <= wait_reg - 16'd1;
        if (wait_reg == 16'd1) busy_reg <= 1'b0;
      end
    end
  end
  // quad enable lives in status two
  assign sr2_p = sr2_reg;
  assign cfg_p = cfg_reg;
  // busy flag in status one bit zero
  assign sr1_p = {7'h00, busy_reg};

  // ----------------------------------------
  // apb slave, zero wait state
  // ----------------------------------------
  wire        sel_sr1  = paddr == QMEC_OFF_SR1;
  wire        sel_sr2  = paddr == QMEC_OFF_SR2;
  wire        sel_cfg  = paddr == QMEC_OFF_CFG;
  wire        sel_stat = paddr == QMEC_OFF_STAT;
  wire        hit      = sel_sr1 | sel_sr2 | sel_cfg | sel_stat;
  wire [31:0] rd_mux   = sel_sr1  ? {24'h000000, sr1_p} :
                         sel_sr2  ? {24'h000000, sr2_reg} :
                         sel_cfg  ? {24'h000000, cfg_reg} :
                         sel_stat ? {30'h00000000, cfg_reg[QMEC_QPI_BIT], cont_p} : 32'h00000000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= '0;
    else if (psel && !penable && !pwrite) prdata <= rd_mux;
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!hit || pwrite);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_busy_on_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_evt |=> busy_reg) else $error("busy not set after write");
  a_busy_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    busy_reg |-> (wait_reg != 16'd0) && (wait_reg <= 16'(WRITE_CYC)))
    else $error("busy count out of range");
  a_quad_from_byte: assert property (@(posedge sck) disable iff (!presetn || cs_n)
    (state_reg == QMEC_S_WR2 && byte_done) |=> wsr2_reg[QMEC_QUAD_EN_BIT] == $past(rx_byte[1]))
    else $error("quad enable not from byte two");
  a_enter_needs_quad: assert property (@(posedge sck) disable iff (!presetn || cs_n)
    (mode_done && !cont_reg && !quad_en_s) |=> !cont_reg)
    else $error("entry without quad enable");
  a_enter_a5: assert property (@(posedge sck) disable iff (!presetn || cs_n)
    (mode_done && mode_enter && state_reg != QMEC_S_DATA) |=> cont_reg)
    else $error("a5 did not enter");
  a_exit_nonax: assert property (@(posedge sck) disable iff (!presetn || cs_n)
    (mode_done && !mode_enter && !mode_keep) |=> !cont_reg) else $error("no exit");
  a_exit_zero: assert property (@(posedge sck) disable iff (!presetn || cs_n)
    (mode_done && mode_byte == QMEC_MODE_EXIT) |=> !cont_reg) else $error("00h kept mode");
  a_sr1_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && sel_sr1 && !pwrite) |=> prdata[0] == $past(busy_reg))
    else $error("status one read wrong");
  c_write: cover property (@(posedge pclk) disable iff (!presetn) wr_evt);
  c_cont:  cover property (@(posedge pclk) disable iff (!presetn) $rose(cont_p));
  c_exit:  cover property (@(posedge pclk) disable iff (!presetn) $fell(cont_p));
endmodule // qmec_top

// ---- tb/qmec_host.sv ----
`timescale 1ns/1ps
// ----------------------------
// host serial controller model
// ----------------------------
module qmec_host (
  // link
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] dq,
  input  wire logic [3:0] dout
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    dq = 4'h0;
  end
  // clock only runs inside frames
  task automatic tick();
    #16 sck = 1'b1;
    #16 sck = 1'b0;
  endtask
  task automatic start();
    cs_n = 1'b0;
    #16;
  endtask
  task automatic stop();
    #16 cs_n = 1'b1;
    dq = ~dq;
    #96;
  endtask
  task automatic put(input logic [7:0] b, input bit q);
    for (int i = 7; i >= 0; i -= (q ? 4 : 1)) begin
      if (q)
        dq = b[i-:4];
      else
        dq[0] = b[i];
      tick();
    end
  endtask
  // released lines toggle, so stale data never reads as valid
  task automatic get(output logic [7:0] b, input bit q);
    b = 8'h00;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      dq = ~dq;
      #16 sck = 1'b1;
      b = q ? {b[3:0], dout} : {b[6:0], dout[1]};
      #16 sck = 1'b0;
    end
  endtask
  task automatic mode_reset();
    start();
    dq = 4'hf;
    repeat (8) tick();
    stop();
  endtask
endmodule // qmec_host

// ---- tb/tb.sv ----
`timescale 1ns/1ps
// ---------
// testbench
// ---------
module tb;
  import qmec_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sck, cs_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  dq, dout, doe;
  int          bad_count = 0;
  int          compares = 0;
  int          cyc = 0;
  qmec_top #(.WRITE_CYC(200)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n), .quad_data_lines_in(dq),
    .quad_data_lines_out(dout), .quad_data_lines_oe(doe));
  qmec_host h (.sck(sck), .cs_n(cs_n), .dq(dq), .dout(dout));
  always #2.5 pclk = ~pclk;
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // pready sampled only with psel and penable high
  task automatic apb(input logic w, input logic [11:0] a, output logic [31:0] d,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // settle time lets link side state cross over
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    logic [31:0] d;
    logic        e;
    repeat (20) @(posedge pclk);
    apb(1'b0, a, d, e);
    check(n, d, x);
    check("pslverr", {31'h0, e}, 32'h0);
  endtask
  task automatic link_rd(input logic [7:0] c, input bit q, output logic [7:0] v);
    h.start();
    h.put(c, q);
    h.get(v, q);
    h.stop();
  endtask
  task automatic poll(input bit q);
    logic [7:0] v;
    link_rd(QMEC_CMD_RDSR1, q, v);
    check("busy", {31'h0, v[QMEC_BUSY_BIT]}, 32'h1);
    for (int n = 0; n < 20 && v[QMEC_BUSY_BIT] !== 1'b0; n++) link_rd(QMEC_CMD_RDSR1, q, v);
    check("ready", {31'h0, v[QMEC_BUSY_BIT]}, 32'h0);
  endtask
  task automatic wr_sr2(input logic [7:0] s);
    h.start();
    h.put(QMEC_CMD_WRSR, 1'b0);
    h.put(8'h00, 1'b0);
    h.put(s, 1'b0);
    h.stop();
    poll(1'b0);
  endtask
  task automatic cfg(input bit q, input logic w, inout logic [7:0] v);
    h.start();
    h.put(w ? QMEC_CMD_CFG_WR : QMEC_CMD_CFG_RD, q);
    for (int i = 2; i >= 0; i--) h.put(QMEC_CFG_ADDR[8*i+:8], 1'b1);
    if (w)
      h.put(v, q);
    else
      h.get(v, q);
    h.stop();
    // the write switches the link width at once, so poll in the new width
    if (w)
      poll(v[QMEC_QPI_BIT]);
  endtask
  task automatic qread(input logic [7:0] m, input bit first);
    logic [7:0] v;
    h.start();
    if (first)
      h.put(QMEC_CMD_QIOR, 1'b0);
    repeat (3) h.put(8'h00, 1'b1);
    h.put(m, 1'b1);
    repeat (4) h.tick();
    h.get(v, 1'b1);
    h.stop();
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic        e;
    rd(QMEC_OFF_SR2, {24'h0, QMEC_SR2_RST}, "sr2 reset");
    rd(QMEC_OFF_CFG, {24'h0, QMEC_CFG_RST}, "cfg reset");
    rd(QMEC_OFF_STAT, 32'h0, "mode reset");
    apb(1'b0, 12'h010, d, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    apb(1'b1, QMEC_OFF_SR2, d, e);
    check("write err", {31'h0, e}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_qe();
    logic [7:0] v;
    wr_sr2(8'h02);
    link_rd(QMEC_CMD_RDSR2, 1'b0, v);
    check("sr2 link", {24'h0, v}, 32'h2);
    rd(QMEC_OFF_SR2, 32'h2, "sr2 quad enable");
    $display("test qe done");
  endtask
  task automatic t_cont();
    qread(QMEC_MODE_ENTER, 1'b1);
    rd(QMEC_OFF_STAT, 32'h1, "enter");
    qread(QMEC_MODE_ENTER, 1'b0);
    rd(QMEC_OFF_STAT, 32'h1, "stay");
    qread(QMEC_MODE_EXIT, 1'b0);
    rd(QMEC_OFF_STAT, 32'h0, "exit 00");
    qread(QMEC_MODE_ENTER, 1'b1);
    qread(8'h5a, 1'b0);
    rd(QMEC_OFF_STAT, 32'h0, "exit nib");
    qread(QMEC_MODE_ENTER, 1'b1);
    // continuous mode entered first, the fh reset frame follows while in it
    h.mode_reset();
    rd(QMEC_OFF_STAT, 32'h0, "exit fh");
    wr_sr2(8'h00);
    rd(QMEC_OFF_SR2, 32'h0, "quad enable clear");
    qread(QMEC_MODE_ENTER, 1'b1);
    rd(QMEC_OFF_STAT, 32'h0, "no quad enable");
    $display("test continuous done");
  endtask
  task automatic t_cfg();
    logic [7:0] v;
    cfg(1'b0, 1'b0, v);
    check("cfg read", {24'h0, v}, {24'h0, QMEC_CFG_RST});
    v[QMEC_QPI_BIT] = 1'b1;
    cfg(1'b0, 1'b1, v);
    rd(QMEC_OFF_STAT, 32'h2, "quad cmd on");
    rd(QMEC_OFF_CFG, 32'h40, "cfg set");
    cfg(1'b1, 1'b0, v);
    check("cfg quad read", {24'h0, v}, 32'h40);
    v[QMEC_QPI_BIT] = 1'b0;
    cfg(1'b1, 1'b1, v);
    rd(QMEC_OFF_STAT, 32'h0, "quad cmd off");
    $display("test config done");
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_qe();
    t_cont();
    t_cfg();
    give_verdict();
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      give_verdict();
    end
  end
endmodule // tb
